// ==== hw/fsc_config_store.sv ====
`timescale 1ns/1ps
// What this block does
// - Three fuse bytes, zero means programmed
// - Extended bit 0 gates store instruction
// - High byte reset, debug, watchdog, keep, brownout
// - Serial interface cannot read or alter bit
// - Forced watchdog disables watchdog interrupt
// - Low byte divider, clock pin, startup, source
// - Defaults pick internal oscillator, longest startup
// - Lock bit one blocks fuse changes
// - Chip erase leaves fuses unchanged
// - Latch on program entry, apply on exit
// - EEPROM keep fuse acts at once
// - Latch at power-up, latched copy drives chip
// - Imprint table addresses for ident and trim
// - Ident bytes readable whatever the lock
// - Every reset loads trim into register
// - Flash page split follows device size
// - EEPROM four-byte pages split by size
// - Erase strobes flash and EEPROM erase, keep honoured
module fsc_config_store
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Programming mode control
  input wire logic progMode,
  input wire logic serialIf,
  input wire logic lockBitOne,
  input wire logic eraseReq,
  // Fuse write
  input wire logic fuseWrEn,
  input wire logic [1:0] fuseWrSel,
  input wire logic [7:0] fuseWrData,
  // Read port
  input wire logic rdReq,
  input wire logic rdFromFuse,
  input wire logic [5:0] rdAddr,
  // Address geometry
  input wire logic [1:0] sizeSel,
  input wire logic [11:0] progCounter,
  input wire logic [8:0] eepromByteAddr,
  // Configuration out
  output fsc_cfg_t cfg_q,
  output logic [7:0] oscTrimRegister_q,
  // Read and status out
  output logic [7:0] rdData_q,
  output logic rdValid_q,
  output logic wrDone_q,
  output logic wrRefused_q,
  output logic eraseFlash_q,
  output logic eraseEeprom_q,
  // Page split out
  output logic [6:0] pageNumberField_q,
  output logic [4:0] wordInPageIndex_q,
  output logic [6:0] eepromPage_q,
  output logic [1:0] eepromByteSel_q
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic fsc_cfg_t fsc_decode(input logic [2:0][7:0] arr);
    fsc_cfg_t c;
    c.storeProgramAllow = ~arr[FUSE_EXT][EXT_SELF_WRITE_BIT];
    c.extResetOff = ~arr[FUSE_HIGH][HIGH_EXT_RESET_BIT];
    c.oneWireDebugOn = ~arr[FUSE_HIGH][HIGH_DEBUG_BIT];
    c.watchdogForcedOn = ~arr[FUSE_HIGH][HIGH_WDOG_BIT];
    c.watchdogIrqOff = ~arr[FUSE_HIGH][HIGH_WDOG_BIT];
    c.eepromKeepOnErase = ~arr[FUSE_HIGH][HIGH_KEEP_BIT];
    c.brownoutLevel = arr[FUSE_HIGH][HIGH_BOD_LSB +: 3];
    c.clockDivEight = ~arr[FUSE_LOW][LOW_DIV8_BIT];
    c.clockToPin = ~arr[FUSE_LOW][LOW_CLKPIN_BIT];
    c.startupSel = arr[FUSE_LOW][LOW_SUT_LSB +: 2];
    c.clockSrc = arr[FUSE_LOW][LOW_CKSEL_LSB +: 4];
    return c;
  endfunction

  function automatic logic [7:0] fsc_sig_read(input logic [5:0] a, input logic [7:0] trim);
    logic [7:0] v;
    v = RESERVED_READ;
    case (a)
      SIG_ID0_ADDR: v = ID0_VAL;
      SIG_TRIM_ADDR: v = trim;
      SIG_ID1_ADDR: v = ID1_VAL;
      SIG_ID2_ADDR: v = ID2_VAL;
      default: v = RESERVED_READ;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_q;
  logic rstN_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q <= rstMeta_q;
    end
  end

  // ----------------------------------------
  // Fuse store and latch
  // ----------------------------------------
  logic [2:0][7:0] fuseArr_q;
  logic [2:0][7:0] fuseArr_d;
  fsc_state_t state_q;
  fsc_state_t state_d;
  fsc_cfg_t latched_q;
  fsc_cfg_t latched_d;
  fsc_cfg_t cfg_d;
  logic [7:0] trim_d;
  logic wrOk;
  logic doLatch;
  logic [7:0] wrVal;

  always_comb begin
    fuseArr_d = fuseArr_q;
    state_d = state_q;
    latched_d = latched_q;
    trim_d = oscTrimRegister_q;
    doLatch = 1'b0;
    wrOk = fuseWrEn && progMode && lockBitOne && (fuseWrSel <= FUSE_LOW);
    wrVal = fuseWrData;
    if (serialIf && fuseWrSel == FUSE_HIGH) begin
      wrVal[HIGH_SERIAL_PROG_BIT] = fuseArr_q[FUSE_HIGH][HIGH_SERIAL_PROG_BIT];
    end
    if (wrOk) begin
      fuseArr_d[fuseWrSel] = wrVal;
    end
    case (state_q)
      ST_PWRUP: begin
        doLatch = 1'b1;
        trim_d = TRIM_VAL;
        state_d = progMode ? ST_PROG : ST_RUN;
      end
      ST_RUN: begin
        if (progMode) begin
          doLatch = 1'b1;
          state_d = ST_PROG;
        end
      end
      ST_PROG: begin
        if (!progMode) begin
          doLatch = 1'b1;
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_PWRUP;
    endcase
    if (doLatch) begin
      latched_d = fsc_decode(fuseArr_q);
    end
    cfg_d = latched_d;
    cfg_d.eepromKeepOnErase = ~fuseArr_q[FUSE_HIGH][HIGH_KEEP_BIT];
  end

  always_ff @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      fuseArr_q <= {LOW_RESET_VAL, HIGH_RESET_VAL, EXT_RESET_VAL};
      state_q <= ST_PWRUP;
      latched_q <= '0;
      cfg_q <= '0;
      oscTrimRegister_q <= TRIM_VAL;
    end else begin
      fuseArr_q <= fuseArr_d;
      state_q <= state_d;
      latched_q <= latched_d;
      cfg_q <= cfg_d;
      oscTrimRegister_q <= trim_d;
    end
  end

  // ----------------------------------------
  // Read, write status and erase
  // ----------------------------------------
  logic [7:0] rdData_d;
  logic rdValid_d;
  logic wrDone_d;
  logic wrRefused_d;
  logic eraseFlash_d;
  logic eraseEeprom_d;

  always_comb begin
    rdData_d = rdData_q;
    rdValid_d = rdReq;
    if (rdReq) begin
      if (rdFromFuse) begin
        rdData_d = (rdAddr[1:0] <= FUSE_LOW) ? fuseArr_q[rdAddr[1:0]] : RESERVED_READ;
        if (serialIf && rdAddr[1:0] == FUSE_HIGH) begin
          rdData_d[HIGH_SERIAL_PROG_BIT] = 1'b1;
        end
      end else begin
        rdData_d = fsc_sig_read(rdAddr, oscTrimRegister_q);
      end
    end
    wrDone_d = wrOk;
    wrRefused_d = fuseWrEn && !wrOk;
    eraseFlash_d = eraseReq && progMode;
    eraseEeprom_d = eraseReq && progMode && fuseArr_q[FUSE_HIGH][HIGH_KEEP_BIT];
  end

  always_ff @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
      wrDone_q <= 1'b0;
      wrRefused_q <= 1'b0;
      eraseFlash_q <= 1'b0;
      eraseEeprom_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      wrDone_q <= wrDone_d;
      wrRefused_q <= wrRefused_d;
      eraseFlash_q <= eraseFlash_d;
      eraseEeprom_q <= eraseEeprom_d;
    end
  end

  // ----------------------------------------
  // Page geometry
  // ----------------------------------------
  logic [6:0] page_d;
  logic [4:0] word_d;
  logic [6:0] eePage_d;

  always_comb begin
    case (sizeSel)
      SIZE_SMALL: begin
        word_d = {1'b0, progCounter[3:0]};
        page_d = {1'b0, progCounter[9:4]};
        eePage_d = {2'b00, eepromByteAddr[6:2]};
      end
      SIZE_MID: begin
        word_d = progCounter[4:0];
        page_d = {1'b0, progCounter[10:5]};
        eePage_d = {1'b0, eepromByteAddr[7:2]};
      end
      default: begin
        word_d = progCounter[4:0];
        page_d = progCounter[11:5];
        eePage_d = eepromByteAddr[8:2];
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      pageNumberField_q <= 7'h00;
      wordInPageIndex_q <= 5'h00;
      eepromPage_q <= 7'h00;
      eepromByteSel_q <= 2'h0;
    end else begin
      pageNumberField_q <= page_d;
      wordInPageIndex_q <= word_d;
      eepromPage_q <= eePage_d;
      eepromByteSel_q <= eepromByteAddr[1:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN_q);

  sequence s_prog_exit;
    state_q == ST_PROG && !progMode;
  endsequence

  sequence s_locked_write;
    fuseWrEn && !lockBitOne;
  endsequence

  chk_locked_refuse: assert property (s_locked_write |=> wrRefused_q && $stable(fuseArr_q))
    else $error("fuse write accepted while locked");
  chk_erase_keeps_fuses: assert property (eraseReq && !fuseWrEn |=> $stable(fuseArr_q))
    else $error("chip erase altered fuses");
  chk_latch_exit: assert property (s_prog_exit |=> cfg_q == fsc_decode($past(fuseArr_q)))
    else $error("fuses not applied on exit");
  chk_latch_hold: assert property (state_q == ST_PROG && progMode && $past(state_q) == ST_PROG
    |=> cfg_q.clockSrc == $past(cfg_q.clockSrc) && cfg_q.brownoutLevel == $past(cfg_q.brownoutLevel))
    else $error("latched config moved in programming mode");
  chk_keep_live: assert property (##1 cfg_q.eepromKeepOnErase == ~$past(fuseArr_q[FUSE_HIGH][HIGH_KEEP_BIT]))
    else $error("keep fuse not immediate");
  chk_trim_load: assert property (state_q == ST_PWRUP |=> oscTrimRegister_q == TRIM_VAL)
    else $error("trim not loaded");
  chk_wdog_irq: assert property (cfg_q.watchdogForcedOn == cfg_q.watchdogIrqOff)
    else $error("watchdog interrupt not disabled");
  chk_serial_hidden: assert property (wrOk && serialIf && fuseWrSel == FUSE_HIGH
    |=> $stable(fuseArr_q[FUSE_HIGH][HIGH_SERIAL_PROG_BIT]))
    else $error("serial write changed hidden fuse");
  chk_ident_read: assert property (rdReq && !rdFromFuse && rdAddr == SIG_ID0_ADDR
    |=> rdValid_q && rdData_q == ID0_VAL)
    else $error("ident byte wrong");
  chk_reserved_read: assert property (rdReq && !rdFromFuse && rdAddr == SIG_LAST_ADDR
    |=> rdData_q == RESERVED_READ ##1 ($stable(cfg_q) || $past(progMode, 2) != $past(progMode) || $past(wrOk, 2)))
    else $error("reserved read wrong");
  chk_erase_eeprom: assert property (eraseReq && progMode && fuseArr_q[FUSE_HIGH][HIGH_KEEP_BIT]
    |=> eraseFlash_q && eraseEeprom_q)
    else $error("erase not issued");
  chk_flash_split: assert property (state_q != ST_PWRUP && sizeSel == SIZE_SMALL
    |=> wordInPageIndex_q == {1'b0, $past(progCounter[3:0])})
    else $error("flash word index wrong");

endmodule // fsc_config_store

// ==== hw/fsc_pkg.sv ====
package fsc_pkg;

  // ----------------------------------------
  // Fuse byte selection
  // ----------------------------------------
  localparam logic [1:0] FUSE_EXT = 2'h0;
  localparam logic [1:0] FUSE_HIGH = 2'h1;
  localparam logic [1:0] FUSE_LOW = 2'h2;

  // ----------------------------------------
  // Fuse defaults, zero means programmed
  // ----------------------------------------
  localparam logic [7:0] EXT_RESET_VAL = 8'hff;
  localparam logic [7:0] HIGH_RESET_VAL = 8'hdf;
  localparam logic [7:0] LOW_RESET_VAL = 8'h62;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EXT_SELF_WRITE_BIT = 0;
  localparam int HIGH_EXT_RESET_BIT = 7;
  localparam int HIGH_DEBUG_BIT = 6;
  localparam int HIGH_SERIAL_PROG_BIT = 5;
  localparam int HIGH_WDOG_BIT = 4;
  localparam int HIGH_KEEP_BIT = 3;
  localparam int HIGH_BOD_LSB = 0;
  localparam int LOW_DIV8_BIT = 7;
  localparam int LOW_CLKPIN_BIT = 6;
  localparam int LOW_SUT_LSB = 4;
  localparam int LOW_CKSEL_LSB = 0;

  // ----------------------------------------
  // Imprint table
  // ----------------------------------------
  localparam logic [5:0] SIG_ID0_ADDR = 6'h00;
  localparam logic [5:0] SIG_TRIM_ADDR = 6'h01;
  localparam logic [5:0] SIG_ID1_ADDR = 6'h02;
  localparam logic [5:0] SIG_ID2_ADDR = 6'h04;
  localparam logic [5:0] SIG_LAST_ADDR = 6'h2a;
  localparam logic [7:0] RESERVED_READ = 8'hff;
  // Identity and trim values are arbitrary
  localparam logic [7:0] ID0_VAL = 8'h5a;
  localparam logic [7:0] ID1_VAL = 8'h3c;
  localparam logic [7:0] ID2_VAL = 8'h21;
  localparam logic [7:0] TRIM_VAL = 8'h80;

  // ----------------------------------------
  // Memory size variants
  // ----------------------------------------
  localparam logic [1:0] SIZE_SMALL = 2'h0;
  localparam logic [1:0] SIZE_MID = 2'h1;
  localparam logic [1:0] SIZE_LARGE = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic storeProgramAllow;
    logic extResetOff;
    logic oneWireDebugOn;
    logic watchdogForcedOn;
    logic watchdogIrqOff;
    logic eepromKeepOnErase;
    logic [2:0] brownoutLevel;
    logic clockDivEight;
    logic clockToPin;
    logic [1:0] startupSel;
    logic [3:0] clockSrc;
  } fsc_cfg_t;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'h1,
    ST_RUN = 3'h2,
    ST_PROG = 3'h4
  } fsc_state_t;

endpackage

// ==== verif/fsc_prog_model.sv ====
`timescale 1ns/1ps
module fsc_prog_model
  import fsc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Answers from the store
  input wire logic [7:0] rdData_q,
  input wire logic rdValid_q,
  input wire logic wrDone_q,
  input wire logic wrRefused_q,
  input wire logic eraseFlash_q,
  input wire logic eraseEeprom_q,
  // Requests to the store
  output logic progMode,
  output logic serialIf,
  output logic lockBitOne,
  output logic eraseReq,
  output logic fuseWrEn,
  output logic [1:0] fuseWrSel,
  output logic [7:0] fuseWrData,
  output logic rdReq,
  output logic rdFromFuse,
  output logic [5:0] rdAddr
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  initial begin
    {progMode, serialIf, eraseReq, fuseWrEn, rdReq, rdFromFuse} = '0;
    lockBitOne = 1'b1;
    fuseWrSel = 2'h0;
    fuseWrData = 8'h00;
    rdAddr = 6'h00;
  end

  // ----------------------------------------
  // Programmer operations
  // ----------------------------------------
  task automatic mode(input logic pm, input logic ser, input logic lk);
    @(posedge sys_clk);
    progMode <= pm;
    serialIf <= ser;
    lockBitOne <= lk;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // Writes d as given, debug and reset-off bits not masked
  task automatic wr(input logic [1:0] s, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    fuseWrEn <= 1'b1;
    fuseWrSel <= s;
    fuseWrData <= d;
    @(posedge sys_clk);
    fuseWrEn <= 1'b0;
    fuseWrData <= ~d;
    #1;
    for (n = 0; n < 3 && wrDone_q !== 1'b1 && wrRefused_q !== 1'b1; n++) @(posedge sys_clk) #1;
    r = {wrDone_q, wrRefused_q};
  endtask

  task automatic rd(input logic f, input logic [5:0] a, output logic [7:0] d);
    int n;
    @(posedge sys_clk);
    rdReq <= 1'b1;
    rdFromFuse <= f;
    rdAddr <= a;
    @(posedge sys_clk);
    rdReq <= 1'b0;
    rdAddr <= ~a;
    #1;
    for (n = 0; n < 3 && rdValid_q !== 1'b1; n++) @(posedge sys_clk) #1;
    d = rdData_q;
  endtask

  task automatic erase(output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    eraseReq <= 1'b1;
    @(posedge sys_clk);
    eraseReq <= 1'b0;
    #1;
    for (n = 0; n < 3 && eraseFlash_q !== 1'b1; n++) @(posedge sys_clk) #1;
    r = {eraseFlash_q, eraseEeprom_q};
  endtask
endmodule // fsc_prog_model

// ==== verif/test_fsc_config_store.sv ====
`timescale 1ns/1ps
`define CHK(g, e) check(64'(g), 64'(e))
module test_fsc_config_store
  import fsc_pkg::*;
;
  logic sys_clk, nrst, progMode, serialIf, lockBitOne, eraseReq, fuseWrEn, rdReq, rdFromFuse;
  logic rdValid_q, wrDone_q, wrRefused_q, eraseFlash_q, eraseEeprom_q;
  logic [1:0] fuseWrSel, sizeSel, eepromByteSel_q, r;
  logic [7:0] fuseWrData, rdData_q, oscTrimRegister_q, d;
  logic [5:0] rdAddr;
  logic [11:0] progCounter;
  logic [8:0] eepromByteAddr;
  logic [6:0] pageNumberField_q, eepromPage_q;
  logic [4:0] wordInPageIndex_q;
  fsc_cfg_t cfg_q;
  int numErrors = 0;
  int samplesChecked = 0;

  // ----------------------------------------
  // Design and programmer
  // ----------------------------------------
  fsc_config_store u_fsc_config_store (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .progMode(progMode),
    .serialIf(serialIf),
    .lockBitOne(lockBitOne),
    .eraseReq(eraseReq),
    .fuseWrEn(fuseWrEn),
    .fuseWrSel(fuseWrSel),
    .fuseWrData(fuseWrData),
    .rdReq(rdReq),
    .rdFromFuse(rdFromFuse),
    .rdAddr(rdAddr),
    .sizeSel(sizeSel),
    .progCounter(progCounter),
    .eepromByteAddr(eepromByteAddr),
    .cfg_q(cfg_q),
    .oscTrimRegister_q(oscTrimRegister_q),
    .rdData_q(rdData_q),
    .rdValid_q(rdValid_q),
    .wrDone_q(wrDone_q),
    .wrRefused_q(wrRefused_q),
    .eraseFlash_q(eraseFlash_q),
    .eraseEeprom_q(eraseEeprom_q),
    .pageNumberField_q(pageNumberField_q),
    .wordInPageIndex_q(wordInPageIndex_q),
    .eepromPage_q(eepromPage_q),
    .eepromByteSel_q(eepromByteSel_q)
  );
  fsc_prog_model u_fsc_prog_model (
    .sys_clk(sys_clk),
    .rdData_q(rdData_q),
    .rdValid_q(rdValid_q),
    .wrDone_q(wrDone_q),
    .wrRefused_q(wrRefused_q),
    .eraseFlash_q(eraseFlash_q),
    .eraseEeprom_q(eraseEeprom_q),
    .progMode(progMode),
    .serialIf(serialIf),
    .lockBitOne(lockBitOne),
    .eraseReq(eraseReq),
    .fuseWrEn(fuseWrEn),
    .fuseWrSel(fuseWrSel),
    .fuseWrData(fuseWrData),
    .rdReq(rdReq),
    .rdFromFuse(rdFromFuse),
    .rdAddr(rdAddr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  function automatic fsc_cfg_t mk(logic [7:0] e, logic [7:0] h, logic [7:0] l);
    fsc_cfg_t c;
    c.storeProgramAllow = ~e[0];
    c.extResetOff = ~h[7];
    c.oneWireDebugOn = ~h[6];
    c.watchdogForcedOn = ~h[4];
    c.watchdogIrqOff = ~h[4];
    c.eepromKeepOnErase = ~h[3];
    c.brownoutLevel = h[2:0];
    c.clockDivEight = ~l[7];
    c.clockToPin = ~l[6];
    c.startupSel = l[5:4];
    c.clockSrc = l[3:0];
    return c;
  endfunction

  task automatic summarize;
    $display("checked %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_imprint;
    logic [5:0] a[7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h2a};
    logic [7:0] e[7] = '{ID0_VAL, TRIM_VAL, ID1_VAL, 8'hff, ID2_VAL, 8'hff, 8'hff};
    logic [7:0] f[4] = '{8'hff, 8'hff, 8'h62, 8'hff};
    u_fsc_prog_model.mode(1'b0, 1'b0, 1'b0);
    foreach (a[i]) begin
      u_fsc_prog_model.rd(1'b0, a[i], d);
      `CHK(d, e[i]);
      `CHK(rdValid_q, 1'b1);
    end
    u_fsc_prog_model.mode(1'b1, 1'b1, 1'b1);
    foreach (f[i]) begin
      u_fsc_prog_model.rd(1'b1, 6'(i), d);
      `CHK(d, f[i]);
    end
    `CHK(cfg_q, mk(8'hff, 8'hdf, 8'h62));
    u_fsc_prog_model.mode(1'b0, 1'b0, 1'b1);
  endtask

  task automatic t_latch;
    u_fsc_prog_model.mode(1'b1, 1'b0, 1'b1);
    u_fsc_prog_model.erase(r);
    `CHK(r, 2'b11);
    u_fsc_prog_model.wr(FUSE_HIGH, 8'hc7, r);
    `CHK(r, 2'b10);
    @(posedge sys_clk) #1;
    `CHK(cfg_q, mk(8'hff, 8'hd7, 8'h62));
    u_fsc_prog_model.wr(FUSE_EXT, 8'hfe, r);
    u_fsc_prog_model.erase(r);
    `CHK(r, 2'b10);
    u_fsc_prog_model.rd(1'b1, 6'h01, d);
    `CHK(d, 8'hc7);
    u_fsc_prog_model.mode(1'b0, 1'b0, 1'b1);
    `CHK(cfg_q, mk(8'hfe, 8'hc7, 8'h62));
  endtask

  task automatic t_lock;
    u_fsc_prog_model.mode(1'b1, 1'b0, 1'b0);
    u_fsc_prog_model.rd(1'b0, SIG_ID2_ADDR, d);
    `CHK(d, ID2_VAL);
    u_fsc_prog_model.wr(FUSE_LOW, 8'h00, r);
    `CHK(r, 2'b01);
    u_fsc_prog_model.mode(1'b1, 1'b0, 1'b1);
    u_fsc_prog_model.wr(2'h3, 8'h00, r);
    `CHK(r, 2'b01);
    u_fsc_prog_model.mode(1'b0, 1'b0, 1'b1);
    u_fsc_prog_model.wr(FUSE_LOW, 8'h00, r);
    `CHK(r, 2'b01);
    u_fsc_prog_model.rd(1'b1, 6'h02, d);
    `CHK(d, 8'h62);
  endtask

  task automatic t_geom;
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      sizeSel <= 2'(s);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(wordInPageIndex_q, progCounter & (s == 0 ? 12'h00f : 12'h01f));
      `CHK(pageNumberField_q, (progCounter >> (s == 0 ? 4 : 5)) & (s == 2 ? 12'h07f : 12'h03f));
      `CHK(eepromPage_q, (eepromByteAddr >> 2) & (s == 0 ? 9'h01f : s == 1 ? 9'h03f : 9'h07f));
      `CHK(eepromByteSel_q, eepromByteAddr[1:0]);
    end
  endtask

  task automatic t_reset;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(oscTrimRegister_q, TRIM_VAL);
    `CHK(cfg_q, mk(EXT_RESET_VAL, HIGH_RESET_VAL, LOW_RESET_VAL));
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    sizeSel = 2'h0;
    progCounter = 12'habc;
    eepromByteAddr = 9'h1a7;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(cfg_q, mk(EXT_RESET_VAL, HIGH_RESET_VAL, LOW_RESET_VAL));
    `CHK(oscTrimRegister_q, TRIM_VAL);
    t_imprint();
    t_latch();
    t_lock();
    t_geom();
    t_reset();
    summarize();
  end

  initial begin
    #(3000 * 8);
    numErrors++;
    summarize();
  end
endmodule // test_fsc_config_store
